// ===== rtl/dvm_pkg.sv
// Overview of operation
// [R01] Master clock near 4 kHz toggles a half-rate phase flop and its complement.
// [R02] A master-clock reset pulse from an output unit restarts the master clock.
// [R03] Four chained shift stages, stepped by the phase, give periods A, B, C, D.
// [R04] Zero period is the NOR of stages; active-low form inverted gives zero.
// [R05] Shift-register reset clears all stages and forces the phase flop set.
// [R06] Keyable 4 kHz sample oscillator is captured as measure flag at zero start.
// [R07] One store pulse per period; all suppressed during shift-register reset.
// [R08] Oscillator enabled by high phase, held off during reset.
// [R09] Four-bit digit counter counts oscillator pulses through all sixteen states, weights 1-2-4-8.
// [R10] Up-range flag at count fifteen, down-range flag at count zero.
// [R11] Range register changes only when measuring, in period A, phase high; the manual lines set and clear it at any time.
// [R12] Two range flops give true and complement code, manual and auto alike.
// [R13] Manual range switches drive four active-low set and clear lines.
// [R14] Digits shown one per period, latter half only, none during zero.
// [R15] Most significant digit shows overrange values up to fifteen.
// [R16] Anode strobe needs its period active and the phase low.
// [R17] In DC-volt or millivolt function the polarity flop follows polarity lines, else holds.
// [R18] Negative and positive lines valid only in period A of a measurement.
// [R19] Stored negative polarity strobes the minus sign in period B, phase low.
// [R20] Decoder maps all sixteen codes from the inverted count lines.
// [R21] Local ground selects one function; remote removes it and remote sets function.
// [R22] Digit counter cleared as each period's counting half begins.
package dvm_pkg;

	// ==========================================================
	// Timing
	localparam int DVM_CLK_HZ       = 250_000_000;
	localparam int DVM_MCLK_HZ      = 4000;
	localparam int DVM_SAMPLE_HZ    = 4000;
	localparam int DVM_MCLK_DIV     = DVM_CLK_HZ / DVM_MCLK_HZ;
	localparam int DVM_SAMPLE_DIV   = DVM_CLK_HZ / DVM_SAMPLE_HZ;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] DVM_OFS_CTRL   = 8'h00;
	localparam logic [7:0] DVM_OFS_STATUS = 8'h04;
	localparam logic [7:0] DVM_OFS_DIGITS = 8'h08;

	// Control fields
	localparam int DVM_CTRL_SRRST_BIT = 0;
	localparam int DVM_CTRL_AUTO_BIT  = 1;
	localparam int DVM_CTRL_KEY_BIT   = 2;
	localparam logic [2:0] DVM_CTRL_RESET = 3'h2;

	// Status fields
	localparam int DVM_ST_CNT_LSB   = 0;
	localparam int DVM_ST_SR_LSB    = 4;
	localparam int DVM_ST_PHASE_BIT = 8;
	localparam int DVM_ST_MEAS_BIT  = 9;
	localparam int DVM_ST_NEG_BIT   = 10;
	localparam int DVM_ST_RANGE_LSB = 12;
	localparam int DVM_ST_UP_BIT    = 14;
	localparam int DVM_ST_DOWN_BIT  = 15;

	// Function count and digits
	localparam int DVM_NUM_FUNC   = 6;
	localparam int DVM_NUM_DIGITS = 4;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
	} dvm_range_s;

	typedef struct packed {
		logic [3:0] store;
		logic [3:0] anode;
		logic       minus;
	} dvm_strobe_s;

	typedef enum logic [1:0] {
		DVM_BUS_IDLE = 2'b01,
		DVM_BUS_ACK  = 2'b10
	} dvm_bus_e;

endpackage : dvm_pkg

// ===== rtl/dvm_tick_gen.sv
`timescale 1ns/10ps
// Divider that pulses once per DIV clocks; restart holds it at count zero
module dvm_tick_gen import dvm_pkg::*; #(
	parameter int DIV = DVM_MCLK_DIV
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic restart_i,
	// Output
	output logic      tick_o
);

	localparam int W = $clog2(DIV + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} dvm_tick_s;

	dvm_tick_s s_q;
	dvm_tick_s s_d;

	// ==========================================================
	// Next state
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (restart_i) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == W'(DIV - 1)) begin
			s_d.cnt  = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	// Register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

endmodule : dvm_tick_gen

// ===== rtl/dvm_digit_decode.sv
`timescale 1ns/10ps
// Sixteen-state cathode decoder, registered; blank gives no cathode
module dvm_digit_decode import dvm_pkg::*; (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Inverted count lines and blank
	input  wire logic [3:0]  code_n_i,
	input  wire logic        blank_i,
	// Cathode selects, one per code
	output logic      [15:0] cathode_o
);

	typedef struct packed {
		logic [15:0] cath;
	} dvm_dec_s;

	dvm_dec_s s_q;
	dvm_dec_s s_d;

	// ==========================================================
	// One line per code, so 10 to 15 show too
	for (genvar i = 0; i < 16; i++) begin : g_line
		always_comb begin
			s_d.cath[i] = ~blank_i && (~code_n_i == 4'(i)); // [R20] [R15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cathode_o = s_q.cath;

endmodule : dvm_digit_decode

// ===== rtl/dvm_timing_ctrl.sv
`timescale 1ns/10ps
// Timing, counting, autorange and display sequencing for the digitizer
module dvm_timing_ctrl import dvm_pkg::*; #(
	parameter int MCLK_DIV   = DVM_MCLK_DIV,
	parameter int SAMPLE_DIV = DVM_SAMPLE_DIV
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	// Timing control lines
	input  wire logic                    mclk_restart_i,
	input  wire logic                    sr_reset_i,
	input  wire logic                    sample_key_i,
	// Oscillator pulses from the modulator
	input  wire logic                    cco_pulse_i,
	// Range switches, active low
	input  wire logic                    manual_low_bit_up_n_i,
	input  wire logic                    manual_high_bit_up_n_i,
	input  wire logic                    manual_low_bit_clear_n_i,
	input  wire logic                    manual_high_bit_clear_n_i,
	// Function selection
	input  wire logic                    remote_select_i,
	input  wire logic [DVM_NUM_FUNC-1:0] local_func_i,
	input  wire logic [DVM_NUM_FUNC-1:0] remote_func_i,
	input  wire logic                    dc_volt_function_low_i,
	input  wire logic                    millivolt_function_low_i,
	// Polarity lines
	input  wire logic                    pol_neg_i,
	input  wire logic                    pol_pos_i,
	// Timing outputs
	output logic                         phase_o,
	output logic                         phase_n_o,
	output logic [3:0]                   period_o,
	output logic                         zero_o,
	output logic                         zero_n_o,
	output logic                         measure_o,
	output logic                         cco_enable_o,
	output logic                         autorange_clock_gate_o,
	// Counter and range
	output logic [3:0]                   count_o,
	output logic                         range_up_o,
	output logic                         range_down_o,
	output dvm_range_s                   range_o,
	// Display and store strobes
	output dvm_strobe_s                  strobe_o,
	output logic [15:0]                  cathode_o,
	output logic [DVM_NUM_FUNC-1:0]      function_o
);

	typedef struct packed {
		dvm_bus_e                  bus;
		logic [31:0]               rdat;
		logic [2:0]                ctrl;
		logic                      phase;
		logic [3:0]                sr;
		logic                      zero_n;
		logic                      zero_prev;
		logic                      samp_req;
		logic                      meas;
		logic                      cco_en;
		logic                      cco_prev;
		logic [3:0]                cnt;
		logic                      up;
		logic                      down;
		logic                      gate;
		logic                      rng_a;
		logic                      rng_b;
		logic                      pol_neg;
		logic [15:0]               digits;
		dvm_strobe_s               stb;
		logic [DVM_NUM_FUNC-1:0]   func;
	} dvm_state_s;

	dvm_state_s s_q;
	dvm_state_s s_d;

	logic mclk_tick;
	logic samp_tick;
	logic sr_rst;
	logic f_fall;
	logic f_rise;
	logic poly_sel;
	logic [31:0] status_w;

	// ==========================================================
	// Oscillators
	// Restart pulse brings the master clock back to a fresh period
	dvm_tick_gen #(.DIV(MCLK_DIV)) u_mclk (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (mclk_restart_i), // [R02]
		.tick_o    (mclk_tick)
	);

	dvm_tick_gen #(.DIV(SAMPLE_DIV)) u_samp (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (1'b0),
		.tick_o    (samp_tick)
	);

	// Decoder sees the inverted count; blanked outside a latter half
	dvm_digit_decode u_dec (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.code_n_i  (~s_q.cnt), // [R20]
		.blank_i   (s_q.phase || (s_q.sr == 4'h0)), // [R14]
		.cathode_o (cathode_o)
	);

	// ==========================================================
	// Helper terms
	assign sr_rst   = sr_reset_i || s_q.ctrl[DVM_CTRL_SRRST_BIT];
	assign f_fall   = mclk_tick && s_q.phase && !sr_rst;
	assign f_rise   = mclk_tick && !s_q.phase && !sr_rst;
	assign poly_sel = !dc_volt_function_low_i || !millivolt_function_low_i;

	always_comb begin
		status_w = '0;
		status_w[DVM_ST_CNT_LSB +: 4]   = s_q.cnt;
		status_w[DVM_ST_SR_LSB +: 4]    = s_q.sr;
		status_w[DVM_ST_PHASE_BIT]      = s_q.phase;
		status_w[DVM_ST_MEAS_BIT]       = s_q.meas;
		status_w[DVM_ST_NEG_BIT]        = s_q.pol_neg;
		status_w[DVM_ST_RANGE_LSB +: 2] = {s_q.rng_b, s_q.rng_a};
		status_w[DVM_ST_UP_BIT]         = s_q.up;
		status_w[DVM_ST_DOWN_BIT]       = s_q.down;
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;

		// Bus: one wait state, ack for a single cycle, unmapped reads zero
		s_d.bus = DVM_BUS_IDLE;
		case (s_q.bus)
			DVM_BUS_IDLE: begin
				if (cyc_i && stb_i) begin
					s_d.bus  = DVM_BUS_ACK;
					s_d.rdat = '0;
					case (adr_i)
						DVM_OFS_CTRL:   s_d.rdat[2:0] = s_q.ctrl;
						DVM_OFS_STATUS: s_d.rdat = status_w;
						DVM_OFS_DIGITS: s_d.rdat[15:0] = s_q.digits;
						default:        s_d.rdat = '0;
					endcase
					if (we_i && sel_i[0] && adr_i == DVM_OFS_CTRL) begin
						s_d.ctrl = dat_i[2:0];
					end
				end
			end
			DVM_BUS_ACK: s_d.bus = DVM_BUS_IDLE;
			default:     s_d.bus = DVM_BUS_IDLE;
		endcase

		// Phase flop toggles on each master tick; reset forces it set
		if (sr_rst) begin
			s_d.phase = 1'b1; // [R05]
			s_d.sr    = 4'h0; // [R05]
		end else if (mclk_tick) begin
			s_d.phase = !s_q.phase; // [R01]
			// Step as the phase rises, so each period opens with its counting half
			if (!s_q.phase) begin
				s_d.sr = {s_q.sr[2:0], ~|s_q.sr}; // [R03]
			end
		end
		s_d.zero_n    = |s_d.sr; // [R04]
		s_d.zero_prev = ~s_q.zero_n;

		// Sample request: oscillator tick or key, consumed at zero start
		if (samp_tick || sample_key_i || s_q.ctrl[DVM_CTRL_KEY_BIT]) begin
			s_d.samp_req = 1'b1;
		end
		if (~s_q.zero_n && !s_q.zero_prev) begin
			s_d.meas     = s_q.samp_req; // [R06]
			s_d.samp_req = samp_tick || sample_key_i || s_q.ctrl[DVM_CTRL_KEY_BIT];
		end

		// Oscillator enable: phase high, never during reset
		s_d.cco_en   = s_d.phase && !sr_rst && (s_d.sr != 4'h0); // [R08]
		s_d.cco_prev = cco_pulse_i;

		// Counter: cleared as the counting half opens, then counts rises
		if (f_rise) begin
			s_d.cnt = 4'h0; // [R22]
		end else if (s_q.cco_en && cco_pulse_i && !s_q.cco_prev) begin
			s_d.cnt = s_q.cnt + 4'h1; // [R09]
		end
		s_d.up   = &s_d.cnt;  // [R10]
		s_d.down = ~|s_d.cnt; // [R10]

		// Capture digit at end of counting half for readback
		if (f_fall) begin
			for (int i = 0; i < DVM_NUM_DIGITS; i++) begin
				if (s_q.sr[i]) begin
					s_d.digits[4*i +: 4] = s_q.cnt;
				end
			end
		end

		// Ranging gate: measuring, period A, phase high
		s_d.gate = s_d.meas && s_d.sr[0] && s_d.phase; // [R11]
		// Autorange decides as the gated half closes
		if (s_q.gate && f_fall && s_q.ctrl[DVM_CTRL_AUTO_BIT]) begin
			if (s_q.up && !(s_q.rng_a && s_q.rng_b)) begin
				{s_d.rng_b, s_d.rng_a} = {s_q.rng_b, s_q.rng_a} + 2'h1; // [R11]
			end else if (s_q.down && (s_q.rng_a || s_q.rng_b)) begin
				{s_d.rng_b, s_d.rng_a} = {s_q.rng_b, s_q.rng_a} - 2'h1; // [R11]
			end
		end
		// Manual switches act as direct sets and clears, winning over auto
		if (!manual_low_bit_up_n_i) begin
			s_d.rng_a = 1'b1; // [R13]
		end else if (!manual_low_bit_clear_n_i) begin
			s_d.rng_a = 1'b0; // [R13]
		end
		if (!manual_high_bit_up_n_i) begin
			s_d.rng_b = 1'b1; // [R13]
		end else if (!manual_high_bit_clear_n_i) begin
			s_d.rng_b = 1'b0; // [R13]
		end

		// Polarity memory: pulsed only in period A of a measurement
		if (poly_sel && s_q.meas && s_q.sr[0]) begin // [R18]
			if (pol_neg_i) begin
				s_d.pol_neg = 1'b1; // [R17]
			end else if (pol_pos_i) begin
				s_d.pol_neg = 1'b0; // [R17]
			end
		end

		// Strobes from next period and phase so outputs align with them
		for (int i = 0; i < DVM_NUM_DIGITS; i++) begin
			s_d.stb.store[i] = s_d.sr[i] && !s_d.phase && !sr_rst; // [R07]
			s_d.stb.anode[i] = s_d.sr[i] && !s_d.phase; // [R16] [R14]
		end
		s_d.stb.minus = s_d.pol_neg && s_d.sr[1] && !s_d.phase; // [R19]

		// Local ground path wins unless remote removes it
		s_d.func = remote_select_i ? remote_func_i : local_func_i; // [R21]
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q          <= '0;
			s_q.bus      <= DVM_BUS_IDLE;
			s_q.ctrl     <= DVM_CTRL_RESET;
			s_q.phase    <= 1'b1;
			// Zero is already high in reset, so no false zero start on release
			s_q.zero_prev <= 1'b1;
			s_q.down     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, all from state flops
	assign dat_o                  = s_q.rdat;
	assign ack_o                  = s_q.bus == DVM_BUS_ACK;
	assign phase_o                = s_q.phase;
	assign phase_n_o              = ~s_q.phase;
	assign period_o               = s_q.sr;
	assign zero_n_o               = s_q.zero_n;
	assign zero_o                 = ~s_q.zero_n; // [R04]
	assign measure_o              = s_q.meas;
	assign cco_enable_o           = s_q.cco_en;
	assign autorange_clock_gate_o = s_q.gate;
	assign count_o                = s_q.cnt;
	assign range_up_o             = s_q.up;
	assign range_down_o           = s_q.down;
	assign range_o                = '{a: s_q.rng_a, a_n: ~s_q.rng_a, b: s_q.rng_b, b_n: ~s_q.rng_b}; // [R12]
	assign strobe_o               = s_q.stb;
	assign function_o             = s_q.func;

	// ==========================================================
	// Checks
	a_reset_phase_set: assert property (@(posedge clk_i) disable iff (rst_i)
		sr_reset_i |=> (phase_o && period_o == 4'h0)) // [R05]
		else $error("shift reset did not clear stages and set phase");

	a_store_off_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		sr_reset_i |=> strobe_o.store == 4'h0) // [R07]
		else $error("store pulse during shift reset");

	a_anode_phase_low: assert property (@(posedge clk_i) disable iff (rst_i)
		|strobe_o.anode |-> (!phase_o && (strobe_o.anode == period_o))) // [R16]
		else $error("anode strobe outside its latter half");

	a_zero_dark: assert property (@(posedge clk_i) disable iff (rst_i)
		zero_o |-> (strobe_o.anode == 4'h0 && !strobe_o.minus)) // [R14]
		else $error("display lit during zero");

	a_period_walk: assert property (@(posedge clk_i) disable iff (rst_i || sr_reset_i || s_q.ctrl[0])
		(period_o != 4'h0 && $changed(period_o)) |-> $past(period_o) == (period_o >> 1)) // [R03]
		else $error("shift register did not step by one stage");

	a_count_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		f_rise |=> count_o == 4'h0) // [R22]
		else $error("counter not cleared at counting half");

	a_up_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		range_up_o |-> count_o == 4'hf) // [R10]
		else $error("up flag without full count");

	a_cco_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		cco_enable_o |-> (phase_o && !zero_o)) // [R08]
		else $error("oscillator enabled outside counting half");

	a_range_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!s_q.gate && manual_low_bit_up_n_i && manual_low_bit_clear_n_i) |=> $stable(range_o.a)) // [R11]
		else $error("range changed outside gated window");

	a_minus_in_b: assert property (@(posedge clk_i) disable iff (rst_i)
		strobe_o.minus |-> (period_o == 4'h2 && !phase_o)) // [R19]
		else $error("minus sign outside period B latter half");

	c_full_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
		zero_o ##1 !zero_o);
	c_measure_set: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(measure_o));
	c_auto_up: cover property (@(posedge clk_i) disable iff (rst_i)
		s_q.gate && range_up_o && f_fall);

	a_pol_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(poly_sel && s_q.meas && s_q.sr[0]) |=> $stable(s_q.pol_neg)) // [R17]
		else $error("polarity memory changed outside its window");

	c_minus_shown: cover property (@(posedge clk_i) disable iff (rst_i)
		strobe_o.minus);

endmodule : dvm_timing_ctrl

// ===== testbench/dvm_far_side.sv
`timescale 1ns/10ps
// ==========================================================
// Far side: oscillator pulse source and polarity detector
module dvm_far_side import dvm_pkg::*; (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Timing seen from the block
	input  wire logic        cco_enable_i,
	input  wire logic [3:0]  period_i,
	input  wire logic        measure_i,
	// Scenario settings, five bits of pulses per period
	input  wire logic [19:0] pulses_i,
	input  wire logic        neg_i,
	// Lines into the block
	output logic             cco_pulse_o,
	output logic             pol_neg_o,
	output logic             pol_pos_o
);
	logic [4:0] left_q;
	logic       en_q;
	logic       tgl_q;
	logic [1:0] idx;

	// Index of the active period
	always_comb begin
		case (period_i)
			4'h2:    idx = 2'h1;
			4'h4:    idx = 2'h2;
			4'h8:    idx = 2'h3;
			default: idx = 2'h0;
		endcase
	end

	// Pulses only while enabled, two clocks each, loaded at enable rise
	always_ff @(posedge clk_i) begin
		en_q  <= cco_enable_i;
		tgl_q <= rst_i ? 1'b0 : ~tgl_q;
		if (rst_i || !cco_enable_i) begin
			cco_pulse_o <= 1'b0;
			left_q      <= 5'h00;
		end else if (!en_q) begin
			left_q <= pulses_i[idx*5 +: 5];
		end else if (cco_pulse_o) begin
			cco_pulse_o <= 1'b0;
			left_q      <= left_q - 5'h01;
		end else if (left_q != 5'h00) begin
			cco_pulse_o <= 1'b1;
		end
	end

	// Polarity valid in period A of a measurement only; garbage elsewhere
	assign pol_neg_o = (measure_i && period_i[0]) ? neg_i : tgl_q;
	assign pol_pos_o = (measure_i && period_i[0]) ? ~neg_i : ~tgl_q;
endmodule : dvm_far_side

// ===== testbench/testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the timing and range control
module testbench import dvm_pkg::*;;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i, period_o, count_o;
	logic [31:0] dat_i, dat_o, rd;
	logic        mclk_restart_i, sr_reset_i, sample_key_i, cco_pulse_i;
	logic        lo_up_n, hi_up_n, lo_clr_n, hi_clr_n, remote_select_i;
	logic [5:0]  local_func_i, remote_func_i, function_o;
	logic        dc_low, mv_low, pol_neg_i, pol_pos_i, neg;
	logic        phase_o, phase_n_o, zero_o, zero_n_o, measure_o, cco_enable_o, gate_o;
	logic        range_up_o, range_down_o, ph;
	dvm_range_s  range_o;
	dvm_strobe_s strobe_o;
	logic [15:0] cathode_o;
	logic [19:0] pulses;
	int          failures, n_compared;
	// Rows: pulses per period beside the digit word they should give
	logic [19:0] row_p [3] = '{{5'd8, 5'd4, 5'd2, 5'd1}, {5'd16, 5'd9, 5'd0, 5'd15}, {5'd13, 5'd12, 5'd11, 5'd10}};
	logic [15:0] row_d [3] = '{16'h8421, 16'h090f, 16'hdcba};

	// Short divisors keep each frame at 400 clocks
	dvm_timing_ctrl #(.MCLK_DIV(40), .SAMPLE_DIV(20)) i_dvm_timing_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mclk_restart_i(mclk_restart_i),
		.sr_reset_i(sr_reset_i), .sample_key_i(sample_key_i), .cco_pulse_i(cco_pulse_i),
		.manual_low_bit_up_n_i(lo_up_n), .manual_high_bit_up_n_i(hi_up_n),
		.manual_low_bit_clear_n_i(lo_clr_n), .manual_high_bit_clear_n_i(hi_clr_n),
		.remote_select_i(remote_select_i), .local_func_i(local_func_i), .remote_func_i(remote_func_i),
		.dc_volt_function_low_i(dc_low), .millivolt_function_low_i(mv_low), .pol_neg_i(pol_neg_i),
		.pol_pos_i(pol_pos_i), .phase_o(phase_o), .phase_n_o(phase_n_o), .period_o(period_o),
		.zero_o(zero_o), .zero_n_o(zero_n_o), .measure_o(measure_o), .cco_enable_o(cco_enable_o),
		.autorange_clock_gate_o(gate_o), .count_o(count_o), .range_up_o(range_up_o),
		.range_down_o(range_down_o), .range_o(range_o), .strobe_o(strobe_o), .cathode_o(cathode_o),
		.function_o(function_o));

	dvm_far_side i_dvm_far_side (
		.clk_i(clk_i), .rst_i(rst_i), .cco_enable_i(cco_enable_o), .period_i(period_o),
		.measure_i(measure_o), .pulses_i(pulses), .neg_i(neg), .cco_pulse_o(cco_pulse_i),
		.pol_neg_o(pol_neg_i), .pol_pos_o(pol_pos_i));

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One classic cycle; waits for ack with no assumed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 100);
		q = dat_o;
		if (n >= 100) begin
			failures++;
			$display("Error ack expected 1 seen timeout");
		end
		cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
	endtask : wb

	// Bounded wait for a period and phase combination
	task automatic hunt(input logic [3:0] pat, input logic p);
		int n;
		n = 0;
		while (!(period_o === pat && phase_o === p) && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 1000) begin
			failures++;
			$display("Error period expected %h seen timeout", pat);
		end
	endtask : hunt

	// Whole conversion frame, checked half by half
	task automatic frame(input logic [19:0] p, input logic [15:0] d, input logic ng);
		logic [3:0] e;
		pulses <= p;
		hunt(4'h0, 1'b0);
		chk("zero pair", {zero_o, zero_n_o}, 2'b10);
		chk("phase pair", {phase_o, phase_n_o}, 2'b01);
		chk("anode in zero", strobe_o.anode, 4'h0);
		for (int i = 0; i < 4; i++) begin
			e = d[i*4 +: 4];
			hunt(4'h1 << i, 1'b1);
			repeat (20) @(posedge clk_i);
			chk("anode counting", strobe_o.anode, 4'h0);
			chk("cco enable", cco_enable_o, 1'b1);
			chk("gate", gate_o, measure_o && i == 0);
			hunt(4'h1 << i, 1'b0);
			chk("count", count_o, e);
			chk("up flag", range_up_o, e == 4'hf);
			chk("down flag", range_down_o, e == 4'h0);
			repeat (20) @(posedge clk_i);
			chk("anode", strobe_o.anode, 4'h1 << i);
			chk("store", strobe_o.store, 4'h1 << i);
			chk("cathode", cathode_o, 16'h1 << e);
			chk("minus", strobe_o.minus, ng && i == 1);
		end
		wb(1'b0, DVM_OFS_DIGITS, 32'h0, rd);
		chk("digits", rd[15:0], d);
	endtask : frame

	task print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Roughly six and a half times the expected run
	initial begin
		#100000;
		failures++;
		$display("Error watchdog expected finish seen hang");
		print_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		failures = 0; n_compared = 0; rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
		adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0; mclk_restart_i = 1'b0; sr_reset_i = 1'b0;
		sample_key_i = 1'b0; lo_up_n = 1'b1; hi_up_n = 1'b1; lo_clr_n = 1'b1; hi_clr_n = 1'b1;
		remote_select_i = 1'b0; local_func_i = 6'h04; remote_func_i = 6'h20;
		dc_low = 1'b1; mv_low = 1'b1; neg = 1'b0; pulses = 20'h0;
		repeat (20) @(posedge clk_i);
		chk("reset state", {phase_o, period_o, count_o, strobe_o}, {1'b1, 8'h00, 9'h000});
		rst_i <= 1'b0;
		wb(1'b0, DVM_OFS_CTRL, 32'h0, rd);
		chk("ctrl reset", rd, {29'h0, DVM_CTRL_RESET});
		wb(1'b0, 8'h0c, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, DVM_OFS_CTRL, 32'h0, rd);
		for (int r = 0; r < 3; r++)
			frame(row_p[r], row_d[r], 1'b0);
		chk("measure", measure_o, 1'b1);
		$display("test table done");
		// Polarity stored, held with function off, then cleared
		dc_low <= 1'b0; neg <= 1'b1;
		frame(row_p[0], row_d[0], 1'b1);
		dc_low <= 1'b1; neg <= 1'b0;
		frame(row_p[0], row_d[0], 1'b1);
		mv_low <= 1'b0;
		frame(row_p[0], row_d[0], 1'b0);
		$display("test polarity done");
		// Autorange steps only in period A
		wb(1'b1, DVM_OFS_CTRL, 32'h2, rd);
		frame(row_p[1], row_d[1], 1'b0);
		chk("range up", range_o, 4'b1001);
		frame({5'd15, 5'd0, 5'd0, 5'd5}, 16'hf005, 1'b0);
		chk("range held", range_o, 4'b1001);
		frame({5'd1, 5'd2, 5'd3, 5'd0}, 16'h1230, 1'b0);
		chk("range down", range_o, 4'b0101);
		$display("test autorange done");
		// Manual lines, up wins over clear
		hi_up_n <= 1'b0; hi_clr_n <= 1'b0;
		for (int n = 0; n < 1000 && range_o.b !== 1'b1; n++) @(posedge clk_i);
		chk("manual up", range_o, 4'b0110);
		hi_up_n <= 1'b1;
		for (int n = 0; n < 1000 && range_o.b !== 1'b0; n++) @(posedge clk_i);
		chk("manual clear", range_o, 4'b0101);
		hi_clr_n <= 1'b1;
		$display("test manual done");
		// Shift reset and master clock restart
		wb(1'b1, DVM_OFS_CTRL, 32'h3, rd);
		repeat (2) @(posedge clk_i);
		chk("soft reset", {phase_o, period_o, strobe_o.store}, 9'h100);
		wb(1'b1, DVM_OFS_CTRL, 32'h2, rd);
		sr_reset_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("shift reset", {phase_o, period_o, strobe_o.store, cco_enable_o}, 10'h200);
		sr_reset_i <= 1'b0;
		mclk_restart_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		ph = phase_o;
		repeat (120) @(posedge clk_i);
		chk("restart hold", phase_o, ph);
		mclk_restart_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("local function", function_o, 6'h04);
		remote_select_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("remote function", function_o, 6'h20);
		$display("test misc done");
		print_verdict();
	end
endmodule : testbench
